//--- clk_route_map.svh
// Purpose: Register offsets, field positions, codes and reset values for
//          the pin clock routing and PLL divider configuration block.
// Assumes: Included by its bare name from every file that needs it.
// Notes:   Definitions only; no logic lives here.
`ifndef CLK_ROUTE_MAP_SVH
`define CLK_ROUTE_MAP_SVH

`define ADDR_DSP_DAC_ROUTE    8'h10
`define ADDR_PUMP_OSR_ROUTE   8'h11
`define ADDR_REF_ROUTE        8'h12
`define ADDR_PRE_DIVIDER      8'h14
`define ADDR_INT_MULTIPLIER   8'h15

`define UPPER_FIELD_HI        6
`define UPPER_FIELD_LO        4
`define LOWER_FIELD_HI        2
`define LOWER_FIELD_LO        0
`define PRE_FIELD_HI          3
`define MULT_FIELD_HI         5

`define ROUTE_PIN_CODE        3'h5
`define ROUTE_RESET           3'h0
`define PRE_RESET             4'h0
`define MULT_RESET            6'h08
`define PRE_PROHIBITED        4'hf
`define MULT_PROHIBITED       6'h00

`define SRC_PIN_DSP           3'h5
`define SRC_PIN_DAC           3'h5
`define SRC_PIN_PUMP          3'h6
`define SRC_PIN_OSR           3'h6
`define SRC_PIN_REF           3'h3

`define RDATA_ZERO            8'h00
`define FACTOR_ONE            5'h01

`endif

//--- clk_route_pkg.sv
// Purpose: Types shared by the pin clock routing block and its testbench.
// Assumes: Used only by package-qualified names.
// Notes:   Structs carry grouped signals across module ports.
package clk_route_pkg;

    // One register access request from the control interface.
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    // Source selectors held elsewhere in the clock tree.
    typedef struct packed {
        logic [2:0] dsp;
        logic [2:0] dac;
        logic [2:0] pump;
        logic [2:0] oversampling_rate_clock;
        logic [2:0] ref_clk;
    } src_select_t;

    // A raw PLL divider and multiplier code pair.
    typedef struct packed {
        logic [3:0] pre;
        logic [5:0] mult;
    } pll_code_t;

endpackage

//--- pin_clock_gate.sv
// Purpose: Pass the synchronised serial data output pin level to one
//          clock divider input when both selectors agree.
// Assumes: i_pin is already synchronised to i_ref_clk.
// Notes:   Output is registered and held low whenever the path is muted.
`timescale 1ns/1ps
`include "clk_route_map.svh"
`default_nettype none

module pin_clock_gate #(
    parameter logic [2:0] PIN_SRC_CODE = 3'h5
) (
    input  wire logic       i_ref_clk,
    input  wire logic       i_rst_b,
    input  wire logic       i_pin,
    input  wire logic [2:0] i_src_sel,
    input  wire logic [2:0] i_route,
    output var  logic       o_clk,
    output var  logic       o_active
);

    logic active;

    // The pin only drives the divider when the source select picks the pin
    // option and the route field holds the pin code; all else is muted.
    assign active = (i_src_sel == PIN_SRC_CODE) &&
                    (i_route == `ROUTE_PIN_CODE);

    // Registered gate; a muted path is held low so no edges leak through.
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_clk    <= 1'b0;
            o_active <= 1'b0;
        end else begin
            o_clk    <= active & i_pin;
            o_active <= active;
        end
    end

    property p_follow;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        active |=> (o_clk == $past(i_pin));
    endproperty
    a_follow: assert property (p_follow)
        else $error("Routed clock does not follow the pin.");

    property p_muted;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        !active [*2] |=> !o_clk && !$rose(o_clk);
    endproperty
    a_muted: assert property (p_muted)
        else $error("Muted clock path produced a high level.");

    property p_reserved;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (i_route[2:1] == 2'b11) |=> !o_active;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("Reserved route code left the path active.");

    property p_wrong_src;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (i_src_sel != PIN_SRC_CODE) |=> !o_active;
    endproperty
    a_wrong_src: assert property (p_wrong_src)
        else $error("Route active without the pin source option.");

endmodule

`default_nettype wire

//--- clock_pin_source_pll_divider.sv
// Purpose: Register file for the five pin clock routing selectors and the
//          PLL pre-divider and integer multiplier, with the gated pin
//          clocks and the effective PLL factors it produces.
// Assumes: Register requests and source selects come from logic on
//          i_ref_clk; the serial data output pin is asynchronous.
// Notes:   Reads return data one cycle after the read strobe.
`timescale 1ns/1ps
`include "clk_route_map.svh"
`default_nettype none

module clock_pin_source_pll_divider (
    input  wire logic                       i_ref_clk,
    input  wire logic                       i_rst_b,
    input  wire clk_route_pkg::reg_req_t    i_reg_req,
    output var  logic [7:0]                 o_reg_rdata,
    input  wire logic                       i_serial_data_output_pin,
    input  wire clk_route_pkg::src_select_t i_src_sel,
    input  wire logic                       i_auto_clock_mode,
    input  wire clk_route_pkg::pll_code_t   i_auto_pll,
    output var  logic                       o_dsp_pin_clk,
    output var  logic                       o_converter_pin_clk,
    output var  logic                       o_pump_pin_clk,
    output var  logic                       o_oversample_pin_clk,
    output var  logic                       o_pll_reference_pin_clk,
    output var  logic [4:0]                 o_pin_route_active,
    output var  logic [4:0]                 o_pll_pre_divide_factor,
    output var  logic [5:0]                 o_pll_integer_multiplier,
    output var  logic                       o_pll_setting_prohibited
);

    // Stored fields; reserved bits are not kept and read back as zero.
    logic [2:0] dsp_clock_pin_route;
    logic [2:0] converter_clock_pin_route;
    logic [2:0] pump_clock_pin_route;
    logic [2:0] oversample_clock_pin_route;
    logic [2:0] pll_reference_pin_route;
    logic [3:0] pll_pre_divide_code;
    logic [5:0] pll_multiplier_code;

    // Pin synchroniser stages.
    logic       pin_meta;
    logic       pin_sync;

    // Decoded write strobes.
    logic       wr_dsp_dac;
    logic       wr_pump_osr;
    logic       wr_ref;
    logic       wr_pre;
    logic       wr_mult;

    // Effective PLL codes after the automatic mode override.
    logic [3:0] next_pre_code;
    logic [5:0] next_mult_code;
    logic [7:0] next_rdata;

    // The pin is a free-running external level; two flops tame it before
    // any gate looks at it, at the cost of two cycles of latency.
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pin_meta <= 1'b0;
            pin_sync <= 1'b0;
        end else begin
            pin_meta <= i_serial_data_output_pin;
            pin_sync <= pin_meta;
        end
    end

    // Address decode of write requests.
    assign wr_dsp_dac  = i_reg_req.wr &&
                         (i_reg_req.addr == `ADDR_DSP_DAC_ROUTE);
    assign wr_pump_osr = i_reg_req.wr &&
                         (i_reg_req.addr == `ADDR_PUMP_OSR_ROUTE);
    assign wr_ref      = i_reg_req.wr && (i_reg_req.addr == `ADDR_REF_ROUTE);
    assign wr_pre      = i_reg_req.wr &&
                         (i_reg_req.addr == `ADDR_PRE_DIVIDER);
    assign wr_mult     = i_reg_req.wr &&
                         (i_reg_req.addr == `ADDR_INT_MULTIPLIER);

    // DSP and DAC routing fields share one register.
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            dsp_clock_pin_route       <= `ROUTE_RESET;
            converter_clock_pin_route <= `ROUTE_RESET;
        end else if (wr_dsp_dac) begin
            dsp_clock_pin_route       <=
                i_reg_req.wdata[`UPPER_FIELD_HI:`UPPER_FIELD_LO];
            converter_clock_pin_route <=
                i_reg_req.wdata[`LOWER_FIELD_HI:`LOWER_FIELD_LO];
        end
    end

    // Charge pump and oversampling routing fields share one register.
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pump_clock_pin_route       <= `ROUTE_RESET;
            oversample_clock_pin_route <= `ROUTE_RESET;
        end else if (wr_pump_osr) begin
            pump_clock_pin_route       <=
                i_reg_req.wdata[`UPPER_FIELD_HI:`UPPER_FIELD_LO];
            oversample_clock_pin_route <=
                i_reg_req.wdata[`LOWER_FIELD_HI:`LOWER_FIELD_LO];
        end
    end

    // PLL reference routing field.
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pll_reference_pin_route <= `ROUTE_RESET;
        end else if (wr_ref) begin
            pll_reference_pin_route <=
                i_reg_req.wdata[`LOWER_FIELD_HI:`LOWER_FIELD_LO];
        end
    end

    // PLL pre-divider code; the prohibited value is stored as written and
    // flagged rather than silently corrected, so software sees its error.
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pll_pre_divide_code <= `PRE_RESET;
        end else if (wr_pre) begin
            pll_pre_divide_code <=
                i_reg_req.wdata[`PRE_FIELD_HI:`LOWER_FIELD_LO];
        end
    end

    // PLL integer multiplier code with its non-zero reset value.
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pll_multiplier_code <= `MULT_RESET;
        end else if (wr_mult) begin
            pll_multiplier_code <=
                i_reg_req.wdata[`MULT_FIELD_HI:`LOWER_FIELD_LO];
        end
    end

    // Automatic mode replaces the programmed codes with derived ones.
    always_comb begin
        if (i_auto_clock_mode) begin
            next_pre_code  = i_auto_pll.pre;
            next_mult_code = i_auto_pll.mult;
        end else begin
            next_pre_code  = pll_pre_divide_code;
            next_mult_code = pll_multiplier_code;
        end
    end

    // Effective factors: P is the code plus one, J is the code itself.
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_pll_pre_divide_factor  <= `FACTOR_ONE;
            o_pll_integer_multiplier <= `MULT_RESET;
        end else begin
            o_pll_pre_divide_factor  <=
                {1'b0, next_pre_code} + `FACTOR_ONE;
            o_pll_integer_multiplier <= next_mult_code;
        end
    end

    // Flags a prohibited code in use so the PLL can be held off safely.
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_pll_setting_prohibited <= 1'b0;
        end else begin
            o_pll_setting_prohibited <=
                (next_pre_code == `PRE_PROHIBITED) ||
                (next_mult_code == `MULT_PROHIBITED);
        end
    end

    // Read multiplexer; unmapped offsets return zero.
    always_comb begin
        next_rdata = `RDATA_ZERO;
        unique case (i_reg_req.addr)
            `ADDR_DSP_DAC_ROUTE: begin
                next_rdata = {1'b0, dsp_clock_pin_route,
                              1'b0, converter_clock_pin_route};
            end
            `ADDR_PUMP_OSR_ROUTE: begin
                next_rdata = {1'b0, pump_clock_pin_route,
                              1'b0, oversample_clock_pin_route};
            end
            `ADDR_REF_ROUTE: begin
                next_rdata = {5'h00, pll_reference_pin_route};
            end
            `ADDR_PRE_DIVIDER: begin
                next_rdata = {4'h0, pll_pre_divide_code};
            end
            `ADDR_INT_MULTIPLIER: begin
                next_rdata = {2'h0, pll_multiplier_code};
            end
            default: begin
                next_rdata = `RDATA_ZERO;
            end
        endcase
    end

    // Read data is registered and held until the next read strobe.
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_reg_rdata <= `RDATA_ZERO;
        end else if (i_reg_req.rd) begin
            o_reg_rdata <= next_rdata;
        end
    end

    // One gate per divider input; each sees its own source select code.
    pin_clock_gate #(.PIN_SRC_CODE(`SRC_PIN_DSP)) u_dsp_gate (
        .i_ref_clk (i_ref_clk),
        .i_rst_b   (i_rst_b),
        .i_pin     (pin_sync),
        .i_src_sel (i_src_sel.dsp),
        .i_route   (dsp_clock_pin_route),
        .o_clk     (o_dsp_pin_clk),
        .o_active  (o_pin_route_active[0])
    );

    pin_clock_gate #(.PIN_SRC_CODE(`SRC_PIN_DAC)) u_dac_gate (
        .i_ref_clk (i_ref_clk),
        .i_rst_b   (i_rst_b),
        .i_pin     (pin_sync),
        .i_src_sel (i_src_sel.dac),
        .i_route   (converter_clock_pin_route),
        .o_clk     (o_converter_pin_clk),
        .o_active  (o_pin_route_active[1])
    );

    pin_clock_gate #(.PIN_SRC_CODE(`SRC_PIN_PUMP)) u_pump_gate (
        .i_ref_clk (i_ref_clk),
        .i_rst_b   (i_rst_b),
        .i_pin     (pin_sync),
        .i_src_sel (i_src_sel.pump),
        .i_route   (pump_clock_pin_route),
        .o_clk     (o_pump_pin_clk),
        .o_active  (o_pin_route_active[2])
    );

    pin_clock_gate #(.PIN_SRC_CODE(`SRC_PIN_OSR)) u_osr_gate (
        .i_ref_clk (i_ref_clk),
        .i_rst_b   (i_rst_b),
        .i_pin     (pin_sync),
        .i_src_sel (i_src_sel.oversampling_rate_clock),
        .i_route   (oversample_clock_pin_route),
        .o_clk     (o_oversample_pin_clk),
        .o_active  (o_pin_route_active[3])
    );

    pin_clock_gate #(.PIN_SRC_CODE(`SRC_PIN_REF)) u_ref_gate (
        .i_ref_clk (i_ref_clk),
        .i_rst_b   (i_rst_b),
        .i_pin     (pin_sync),
        .i_src_sel (i_src_sel.ref_clk),
        .i_route   (pll_reference_pin_route),
        .o_clk     (o_pll_reference_pin_clk),
        .o_active  (o_pin_route_active[4])
    );

    property p_dsp_route_write;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        wr_dsp_dac |=> (dsp_clock_pin_route ==
                        $past(i_reg_req.wdata[`UPPER_FIELD_HI:
                                              `UPPER_FIELD_LO]));
    endproperty
    a_dsp_route_write: assert property (p_dsp_route_write)
        else $error("DSP route field not taken from bits 6-4.");

    property p_ref_route_active;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (pll_reference_pin_route == `ROUTE_PIN_CODE) &&
        (i_src_sel.ref_clk == `SRC_PIN_REF)
        |=> o_pin_route_active[4];
    endproperty
    a_ref_route_active: assert property (p_ref_route_active)
        else $error("PLL reference pin route not activated.");

    property p_pre_manual;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        !i_auto_clock_mode |=>
            (o_pll_pre_divide_factor ==
             {1'b0, $past(pll_pre_divide_code)} + `FACTOR_ONE);
    endproperty
    a_pre_manual: assert property (p_pre_manual)
        else $error("Pre-divide factor is not code plus one.");

    property p_auto_override;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        i_auto_clock_mode |=>
            (o_pll_integer_multiplier == $past(i_auto_pll.mult)) &&
            (o_pll_pre_divide_factor ==
             {1'b0, $past(i_auto_pll.pre)} + `FACTOR_ONE);
    endproperty
    a_auto_override: assert property (p_auto_override)
        else $error("Automatic mode did not override PLL codes.");

    property p_mult_write;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        wr_mult ##1 !i_auto_clock_mode |=>
            (o_pll_integer_multiplier ==
             $past(i_reg_req.wdata[`MULT_FIELD_HI:`LOWER_FIELD_LO], 2));
    endproperty
    a_mult_write: assert property (p_mult_write)
        else $error("Multiplier output does not equal written code.");

    property p_mult_reset;
        @(posedge i_ref_clk)
        !i_rst_b |=> (pll_multiplier_code == `MULT_RESET);
    endproperty
    a_mult_reset: assert property (p_mult_reset)
        else $error("Multiplier field did not reset to eight.");

endmodule

`default_nettype wire

//--- clock_pin_source_pll_divider_tb.sv
// Purpose: Self-checking bench for the pin clock routing and PLL divider
//          configuration block, driven through its register strobes.
// Assumes: Inputs change 1 ns after the rising edge; pin path lag is 3 edges.
// Notes:   Expected values come from the register map, not from outputs.
`timescale 1ns/1ps
`include "clk_route_map.svh"
`default_nettype none

module clock_pin_source_pll_divider_tb;
    logic                       i_ref_clk;
    logic                       i_rst_b;
    clk_route_pkg::reg_req_t    req;
    logic [7:0]                 rdata;
    logic                       pin;
    clk_route_pkg::src_select_t src;
    logic                       auto_mode;
    clk_route_pkg::pll_code_t   auto_pll;
    logic [4:0]                 pin_clks;
    logic [4:0]                 active;
    logic [4:0]                 p_factor;
    logic [5:0]                 j_factor;
    logic                       prohibited;
    int                         bad_count;
    int                         tests_run;
    logic [7:0]                 sel_addr [5];
    logic [7:0]                 sel_val  [5];

    clock_pin_source_pll_divider i_clock_pin_source_pll_divider (
        .i_ref_clk                (i_ref_clk),
        .i_rst_b                  (i_rst_b),
        .i_reg_req                (req),
        .o_reg_rdata              (rdata),
        .i_serial_data_output_pin (pin),
        .i_src_sel                (src),
        .i_auto_clock_mode        (auto_mode),
        .i_auto_pll               (auto_pll),
        .o_dsp_pin_clk            (pin_clks[0]),
        .o_converter_pin_clk      (pin_clks[1]),
        .o_pump_pin_clk           (pin_clks[2]),
        .o_oversample_pin_clk     (pin_clks[3]),
        .o_pll_reference_pin_clk  (pin_clks[4]),
        .o_pin_route_active       (active),
        .o_pll_pre_divide_factor  (p_factor),
        .o_pll_integer_multiplier (j_factor),
        .o_pll_setting_prohibited (prohibited)
    );

    // Free-running reference clock at 10 MHz.
    initial begin
        i_ref_clk = 1'b0;
        forever #50 i_ref_clk = ~i_ref_clk;
    end

    // Compare one observed value with its expectation and count both.
    task automatic check(input string name, input logic [7:0] seen,
                         input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Step n rising edges and land just after the last one.
    task automatic tick(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask

    // One write strobe, held across exactly one taking edge. An idle edge
    // follows so the next request never overwrites this one in one step.
    task automatic wr_reg(input logic [7:0] addr, input logic [7:0] data);
        req = '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
        tick(1);
        req = '0;
        tick(1);
    endtask

    // One read strobe; the data is sampled a full cycle later so the
    // registered answer has surely landed.
    task automatic rd_reg(input logic [7:0] addr, input logic [7:0] exp);
        req = '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
        tick(1);
        req = '0;
        tick(1);
        check("read data", rdata, exp);
    endtask

    // Print the tallies and the verdict, then stop the run.
    task automatic finish_test;
        $display("Checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Watchdog: the sequence needs a few hundred cycles at most.
    initial begin
        #(100 * 30000);
        bad_count++;
        finish_test();
    end

    // Main sequence.
    initial begin
        bad_count = 0;
        tests_run = 0;
        i_rst_b   = 1'b0;
        req       = '0;
        pin       = 1'b0;
        auto_mode = 1'b0;
        auto_pll  = '0;
        src       = '{dsp: `SRC_PIN_DSP, dac: `SRC_PIN_DAC,
                      pump: `SRC_PIN_PUMP, oversampling_rate_clock: `SRC_PIN_OSR,
                      ref_clk: `SRC_PIN_REF};
        sel_addr  = '{`ADDR_DSP_DAC_ROUTE, `ADDR_DSP_DAC_ROUTE,
                      `ADDR_PUMP_OSR_ROUTE, `ADDR_PUMP_OSR_ROUTE,
                      `ADDR_REF_ROUTE};
        sel_val   = '{8'h50, 8'h05, 8'h50, 8'h05, 8'h05};
        tick(3);
        i_rst_b = 1'b1;
        tick(1);
        // Reset values of every register and of the factor outputs.
        rd_reg(`ADDR_DSP_DAC_ROUTE, 8'h00);
        rd_reg(`ADDR_PUMP_OSR_ROUTE, 8'h00);
        rd_reg(`ADDR_REF_ROUTE, 8'h00);
        rd_reg(`ADDR_PRE_DIVIDER, 8'h00);
        rd_reg(`ADDR_INT_MULTIPLIER, 8'h08);
        check("j factor", {2'b00, j_factor}, 8'h08);
        check("p factor", {3'b000, p_factor}, 8'h01);
        check("active", {3'b000, active}, 8'h00);
        // Unmapped place and reserved bits.
        wr_reg(8'h13, 8'hff);
        rd_reg(8'h13, 8'h00);
        wr_reg(`ADDR_DSP_DAC_ROUTE, 8'hff);
        rd_reg(`ADDR_DSP_DAC_ROUTE, 8'h77);
        wr_reg(`ADDR_PUMP_OSR_ROUTE, 8'hff);
        rd_reg(`ADDR_PUMP_OSR_ROUTE, 8'h77);
        wr_reg(`ADDR_REF_ROUTE, 8'hff);
        rd_reg(`ADDR_REF_ROUTE, 8'h07);
        wr_reg(`ADDR_PRE_DIVIDER, 8'hfe);
        rd_reg(`ADDR_PRE_DIVIDER, 8'h0e);
        wr_reg(`ADDR_INT_MULTIPLIER, 8'hff);
        rd_reg(`ADDR_INT_MULTIPLIER, 8'h3f);
        // Each selector field alone enables only its own path.
        wr_reg(`ADDR_DSP_DAC_ROUTE, 8'h00);
        wr_reg(`ADDR_PUMP_OSR_ROUTE, 8'h00);
        wr_reg(`ADDR_REF_ROUTE, 8'h00);
        pin = 1'b1;
        for (int k = 0; k < 5; k++) begin
            wr_reg(sel_addr[k], sel_val[k]);
            tick(4);
            check("one path", {3'b000, active}, 8'h01 << k);
            check("one clock", {3'b000, pin_clks}, 8'h01 << k);
            wr_reg(sel_addr[k], 8'h00);
        end
        // Every route code on all five paths at once; only 101 passes.
        for (int c = 0; c < 8; c++) begin
            wr_reg(`ADDR_DSP_DAC_ROUTE, {1'b0, c[2:0], 1'b0, c[2:0]});
            wr_reg(`ADDR_PUMP_OSR_ROUTE, {1'b0, c[2:0], 1'b0, c[2:0]});
            wr_reg(`ADDR_REF_ROUTE, {5'b00000, c[2:0]});
            pin = 1'b1;
            tick(5);
            check("route code", {3'b000, active}, (c == 5) ? 8'h1f : 8'h00);
            check("pin high", {3'b000, pin_clks}, (c == 5) ? 8'h1f : 8'h00);
            pin = 1'b0;
            tick(5);
            check("pin low", {3'b000, pin_clks}, 8'h00);
        end
        // The loop left reserved codes behind; put every route on 101.
        wr_reg(`ADDR_DSP_DAC_ROUTE, 8'h55);
        wr_reg(`ADDR_PUMP_OSR_ROUTE, 8'h55);
        wr_reg(`ADDR_REF_ROUTE, 8'h05);
        // Route 101 but source selects off the pin option: all muted, then ref and dsp selects put back one by one.
        src = '0;
        pin = 1'b1;
        tick(5);
        check("src off", {3'b000, active}, 8'h00);
        check("src off clk", {3'b000, pin_clks}, 8'h00);
        src.ref_clk = `SRC_PIN_REF;
        tick(5);
        check("ref only", {3'b000, active}, 8'h10);
        src.dsp = `SRC_PIN_DSP;
        tick(5);
        check("dsp and ref", {3'b000, pin_clks}, 8'h11);
        // Every legal pre-divider code; software never writes 1111.
        for (int c = 0; c < 15; c++) begin
            wr_reg(`ADDR_PRE_DIVIDER, {4'h0, c[3:0]});
            tick(2);
            check("p factor", {3'b000, p_factor}, 8'(c + 1));
            check("p flag", {7'h00, prohibited}, 8'h00);
        end
        wr_reg(`ADDR_PRE_DIVIDER, 8'h00);
        // Every legal multiplier code; software never writes all zeros.
        for (int c = 1; c < 64; c++) begin
            wr_reg(`ADDR_INT_MULTIPLIER, {2'b00, c[5:0]});
            tick(2);
            check("j factor", {2'b00, j_factor}, 8'(c));
            check("j flag", {7'h00, prohibited}, 8'h00);
        end
        // Back-to-back write then read of the multiplier.
        wr_reg(`ADDR_INT_MULTIPLIER, 8'h10);
        rd_reg(`ADDR_INT_MULTIPLIER, 8'h10);
        check("j walk", {2'b00, j_factor}, 8'h10);
        // Automatic mode overrides both programmed codes, and releases them.
        auto_pll  = '{pre: 4'h3, mult: 6'h14};
        auto_mode = 1'b1;
        tick(2);
        check("auto p", {3'b000, p_factor}, 8'h04);
        check("auto j", {2'b00, j_factor}, 8'h14);
        rd_reg(`ADDR_INT_MULTIPLIER, 8'h10);
        auto_pll.pre = 4'hf;
        tick(2);
        check("auto flag", {7'h00, prohibited}, 8'h01);
        // A derived all-zero multiplier is flagged as well.
        auto_pll = '{pre: 4'h3, mult: 6'h00};
        tick(2);
        check("auto j flag", {7'h00, prohibited}, 8'h01);
        auto_mode = 1'b0;
        tick(2);
        check("manual p", {3'b000, p_factor}, 8'h01);
        check("manual j", {2'b00, j_factor}, 8'h10);
        // A second reset in mid-run restores the defaults.
        i_rst_b = 1'b0;
        tick(1);
        check("reset j", {2'b00, j_factor}, 8'h08);
        check("reset clk", {3'b000, pin_clks}, 8'h00);
        i_rst_b = 1'b1;
        tick(2);
        rd_reg(`ADDR_INT_MULTIPLIER, 8'h08);
        rd_reg(`ADDR_REF_ROUTE, 8'h00);
        finish_test();
    end
endmodule

`default_nettype wire
